// *** bridge_primary_status.sv ***
// Primary status half-word with command enables, reached over APB
// How it works
// - Bit 20 always reads one
// - Bit 21 reads zero forward, one reverse
// - Bit 23 reads zero forward, one reverse
// - Bit 24 forward: poisoned completion or write
// - Bit 24 reverse: parity error cases
// - Flags 24,27-31 sticky, write one clears
// - Bits 26:25 read 00 forward, 01 reverse
// - Bit 27 forward: completer abort sent
// - Bit 27 reverse: target abort signalled
// - Bit 28 forward: completer abort received
// - Bit 28 reverse: target abort observed
// - Bit 29 forward: unsupported request received
// - Bit 29 reverse: master abort experienced
// - Bit 30 forward: error message sent
// - Bit 30 reverse: system error driven
// - Bit 31 forward: poisoned packet received
// - Bit 31 reverse: parity error detected
// - Command bit 6 gates bit 24
// - Command bit 8 enables error signalling
//
// The APB slave port is this design's own decision.
module bridge_primary_status (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [bridge_status_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                      pwdata,
   input  wire logic [3:0]                       pstrb,
   output logic                                  pready,
   output logic [31:0]                           prdata,
   output logic                                  pslverr,
   input  wire logic                             reverse_mode_strap,
   input  wire logic                             primary_parity_error_pin_n,
   input  wire bridge_status_pkg::fwd_events_t   fwd_events,
   input  wire bridge_status_pkg::rev_events_t   rev_events,
   output logic                                  perr_resp_en,
   output logic                                  serr_en,
   output logic                                  reverse_mode,
   output logic [5:0]                            status_flags
);
   import bridge_status_pkg::*;

   // Pin synchronisers
   logic [2:0]  strap_sync_reg;
   logic [2:0]  strap_sync_next;
   logic [2:0]  perr_sync_reg;
   logic [2:0]  perr_sync_next;
   logic        reverse_reg;
   logic        reverse_next;
   logic        perr_pin_low_reg;
   logic        perr_pin_low_next;

   // Command enables
   logic        perr_resp_reg;
   logic        perr_resp_next;
   logic        serr_en_reg;
   logic        serr_en_next;

   // Sticky flags
   logic [5:0]  flags_reg;
   logic [5:0]  flags_next;
   logic [5:0]  flag_set;
   logic [5:0]  flag_clr;

   // APB response
   logic        pready_reg;
   logic        pready_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pslverr_reg;
   logic        pslverr_next;

   logic        hit;
   logic        wr_take;

   // Full 32-bit word: command low, status high
   function automatic logic [31:0] build_word(input logic       rev,
                                              input logic       perr_en,
                                              input logic       s_en,
                                              input logic [5:0] fl);
      logic [31:0] w;
      w                                       = 32'h0000_0000;
      w[CMD_PERR_RESP_BIT]                    = perr_en;
      w[CMD_SERR_EN_BIT]                      = s_en;
      w[ST_CAP_LIST_BIT]                      = 1'b1;
      w[ST_66MHZ_BIT]                         = rev;
      w[ST_FAST_B2B_BIT]                      = rev;
      w[ST_MDPE_BIT]                          = fl[FL_MDPE];
      w[ST_SEL_TIMING_LO +: 2]                = rev ? SEL_TIMING_MEDIUM
                                                    : SEL_TIMING_FAST;
      w[ST_SIG_TABORT_BIT]                    = fl[FL_SIG_TABORT];
      w[ST_RCV_TABORT_BIT]                    = fl[FL_RCV_TABORT];
      w[ST_RCV_MABORT_BIT]                    = fl[FL_RCV_MABORT];
      w[ST_SIG_SERR_BIT]                      = fl[FL_SIG_SERR];
      w[ST_DET_PERR_BIT]                      = fl[FL_DET_PERR];
      // Bits 19:16 and 22 stay zero
      return w;
   endfunction : build_word

   // Expand byte strobes into a bit mask
   function automatic logic [31:0] strobe_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{s[i]}};
      end
      return m;
   endfunction : strobe_mask

   // Synchronisers and mode capture
   always_comb begin
      strap_sync_next   = {strap_sync_reg[1:0], reverse_mode_strap};
      perr_sync_next    = {perr_sync_reg[1:0], primary_parity_error_pin_n};
      reverse_next      = reverse_reg;
      perr_pin_low_next = perr_pin_low_reg;
      // A change counts only when stages two and three agree
      if (strap_sync_reg[1] == strap_sync_reg[2]) begin
         reverse_next = strap_sync_reg[2];
      end
      if (perr_sync_reg[1] == perr_sync_reg[2]) begin
         perr_pin_low_next = ~perr_sync_reg[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_sync_reg   <= STRAP_SYNC_RESET;
         perr_sync_reg    <= PIN_SYNC_RESET;
         reverse_reg      <= REVERSE_RESET;
         perr_pin_low_reg <= 1'b0;
      end else begin
         strap_sync_reg   <= strap_sync_next;
         perr_sync_reg    <= perr_sync_next;
         reverse_reg      <= reverse_next;
         perr_pin_low_reg <= perr_pin_low_next;
      end
   end

   // APB decode and response
   assign hit     = (paddr == CMD_STATUS_OFFSET);
   assign wr_take = psel & penable & pready_reg & pwrite & hit;

   always_comb begin
      pready_next  = 1'b0;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      // No wait state: answer prepared during the setup cycle
      if (psel && !penable) begin
         pready_next  = 1'b1;
         pslverr_next = ~hit;
         if (!pwrite) begin
            prdata_next = hit ? build_word(reverse_reg, perr_resp_reg,
                                           serr_en_reg, flags_reg)
                              : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Command enables
   always_comb begin
      logic [31:0] m;
      m              = strobe_mask(pstrb);
      perr_resp_next = perr_resp_reg;
      serr_en_next   = serr_en_reg;
      if (wr_take && m[CMD_PERR_RESP_BIT]) begin
         perr_resp_next = pwdata[CMD_PERR_RESP_BIT];
      end
      if (wr_take && m[CMD_SERR_EN_BIT]) begin
         serr_en_next = pwdata[CMD_SERR_EN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perr_resp_reg <= PERR_RESP_RESET;
         serr_en_reg   <= SERR_EN_RESET;
      end else begin
         perr_resp_reg <= perr_resp_next;
         serr_en_reg   <= serr_en_next;
      end
   end

   // Flag set conditions per mode
   always_comb begin
      flag_set = 6'h00;
      if (!reverse_reg) begin
         flag_set[FL_MDPE]       = perr_resp_reg &
                                   (fwd_events.poisoned_cpl_rx |
                                    fwd_events.poisoned_wr_tx);
         flag_set[FL_SIG_TABORT] = fwd_events.ca_cpl_tx;
         flag_set[FL_RCV_TABORT] = fwd_events.ca_cpl_rx;
         flag_set[FL_RCV_MABORT] = fwd_events.ur_cpl_rx;
         flag_set[FL_SIG_SERR]   = serr_en_reg & fwd_events.err_msg_tx;
         flag_set[FL_DET_PERR]   = fwd_events.poisoned_tlp_rx;
      end else begin
         flag_set[FL_MDPE]       = perr_resp_reg &
                                   (rev_events.rd_data_parity_err |
                                    (rev_events.wr_data_phase & perr_pin_low_reg) |
                                    rev_events.scm_wr_parity_err);
         flag_set[FL_SIG_TABORT] = rev_events.target_abort_tx;
         flag_set[FL_RCV_TABORT] = rev_events.target_abort_rx;
         flag_set[FL_RCV_MABORT] = rev_events.master_abort;
         flag_set[FL_SIG_SERR]   = serr_en_reg & rev_events.serr_driven;
         flag_set[FL_DET_PERR]   = rev_events.parity_err_detected;
      end
   end

   // Write-one-to-clear, gated by byte lane 3
   always_comb begin
      flag_clr = 6'h00;
      if (wr_take && pstrb[3]) begin
         flag_clr[FL_MDPE]       = pwdata[ST_MDPE_BIT];
         flag_clr[FL_SIG_TABORT] = pwdata[ST_SIG_TABORT_BIT];
         flag_clr[FL_RCV_TABORT] = pwdata[ST_RCV_TABORT_BIT];
         flag_clr[FL_RCV_MABORT] = pwdata[ST_RCV_MABORT_BIT];
         flag_clr[FL_SIG_SERR]   = pwdata[ST_SIG_SERR_BIT];
         flag_clr[FL_DET_PERR]   = pwdata[ST_DET_PERR_BIT];
      end
      flags_next = (flags_reg & ~flag_clr) | flag_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign pready       = pready_reg;
   assign prdata       = prdata_reg;
   assign pslverr      = pslverr_reg;
   assign perr_resp_en = perr_resp_reg;
   assign serr_en      = serr_en_reg;
   assign reverse_mode = reverse_reg;
   assign status_flags = flags_reg;

endmodule : bridge_primary_status

// *** bridge_status_pkg.sv ***
// Constants and carrier types for the primary status half-word block
package bridge_status_pkg;

   // Register map (byte addresses, APB word aligned)
   localparam logic [11:0] CMD_STATUS_OFFSET  = 12'h004;
   localparam int          ADDR_W             = 12;

   // Command half-word fields kept by this block
   localparam int          CMD_PERR_RESP_BIT  = 6;
   localparam int          CMD_SERR_EN_BIT    = 8;
   localparam logic [15:0] CMD_WRITABLE_MASK  = 16'h0140;

   // Status field positions within the 32-bit word
   localparam int          ST_CAP_LIST_BIT    = 20;
   localparam int          ST_66MHZ_BIT       = 21;
   localparam int          ST_FAST_B2B_BIT    = 23;
   localparam int          ST_MDPE_BIT        = 24;
   localparam int          ST_SEL_TIMING_LO   = 25;
   localparam int          ST_SIG_TABORT_BIT  = 27;
   localparam int          ST_RCV_TABORT_BIT  = 28;
   localparam int          ST_RCV_MABORT_BIT  = 29;
   localparam int          ST_SIG_SERR_BIT    = 30;
   localparam int          ST_DET_PERR_BIT    = 31;

   // Select timing codes
   localparam logic [1:0]  SEL_TIMING_FAST    = 2'h0;
   localparam logic [1:0]  SEL_TIMING_MEDIUM  = 2'h1;

   // Reset values
   localparam logic [5:0]  FLAGS_RESET        = 6'h00;
   localparam logic        PERR_RESP_RESET    = 1'b0;
   localparam logic        SERR_EN_RESET      = 1'b0;
   localparam logic        REVERSE_RESET      = 1'b0;
   localparam logic [2:0]  PIN_SYNC_RESET     = 3'h7;
   localparam logic [2:0]  STRAP_SYNC_RESET   = 3'h0;

   // Index of each sticky flag in the flag vector
   localparam int          FL_MDPE            = 0;
   localparam int          FL_SIG_TABORT      = 1;
   localparam int          FL_RCV_TABORT      = 2;
   localparam int          FL_RCV_MABORT      = 3;
   localparam int          FL_SIG_SERR        = 4;
   localparam int          FL_DET_PERR        = 5;

   // One-cycle event pulses from the forward (link) datapath
   typedef struct packed {
      logic poisoned_cpl_rx;
      logic poisoned_wr_tx;
      logic ca_cpl_tx;
      logic ca_cpl_rx;
      logic ur_cpl_rx;
      logic err_msg_tx;
      logic poisoned_tlp_rx;
   } fwd_events_t;

   // Events from the reverse (conventional bus) datapath
   typedef struct packed {
      logic rd_data_parity_err;
      logic wr_data_phase;
      logic scm_wr_parity_err;
      logic target_abort_tx;
      logic target_abort_rx;
      logic master_abort;
      logic serr_driven;
      logic parity_err_detected;
   } rev_events_t;

endpackage : bridge_status_pkg

// *** far_side_model.sv ***
// Link and bus agents that raise error events toward the bridge
module far_side_model (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      go,
   input  wire logic                      rev,
   input  wire logic [2:0]                idx,
   input  wire logic                      pin_err,
   output bridge_status_pkg::fwd_events_t fwd_events,
   output bridge_status_pkg::rev_events_t rev_events,
   output logic                           primary_parity_error_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import bridge_status_pkg::*;
   logic [6:0] fwd_reg;
   logic [7:0] rev_reg;
   logic [3:0] wr_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_reg <= 7'h00;
         rev_reg <= 8'h00;
         wr_cnt  <= 4'h0;
      end else begin
         fwd_reg <= (go && !rev) ? 7'h01 << idx : 7'h00;
         rev_reg <= (go && rev && !pin_err) ? 8'h01 << idx : 8'h00;
         wr_cnt  <= (go && rev && pin_err) ? 4'h8 : wr_cnt - {3'h0, wr_cnt != 4'h0};
      end
   end
   // Write data phase with the error pin pulled low; released to pull-up
   assign fwd_events = fwd_events_t'(fwd_reg);
   assign rev_events = rev_events_t'(rev_reg | {1'b0, wr_cnt != 4'h0, 6'h00});
   assign primary_parity_error_pin_n = (wr_cnt == 4'h0);
endmodule : far_side_model

// *** status_props.sv ***
// Concurrent checks on the primary status block ports
module status_props (
   input wire logic                           pclk,
   input wire logic                           presetn,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [11:0]                    paddr,
   input wire logic [31:0]                    pwdata,
   input wire logic [3:0]                     pstrb,
   input wire logic                           pready,
   input wire logic [31:0]                    prdata,
   input wire logic                           pslverr,
   input wire bridge_status_pkg::fwd_events_t fwd_events,
   input wire bridge_status_pkg::rev_events_t rev_events,
   input wire logic                           perr_resp_en,
   input wire logic                           serr_en,
   input wire logic                           reverse_mode,
   input wire logic [5:0]                     status_flags
);
   import bridge_status_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_ok;
   logic clr31;
   assign rd_ok = pready && !pwrite && !pslverr;
   assign clr31 = psel && penable && pready && pwrite && pstrb[3] && pwdata[31];
   answer_next_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   unmapped_err_a: assert property (pready |-> pslverr == (paddr != CMD_STATUS_OFFSET))
      else $error("error response wrong");
   cap_list_a: assert property (rd_ok |-> prdata[20]) else $error("bit 20 low");
   mode_caps_a: assert property (rd_ok |->
      prdata[21] == $past(reverse_mode) && prdata[23] == $past(reverse_mode) &&
      prdata[26:25] == {1'b0, $past(reverse_mode)})
      else $error("mode bits wrong");
   rsvd_zero_a: assert property (rd_ok |-> prdata[19:16] == 4'h0 && !prdata[22])
      else $error("reserved bits set");
   flag_view_a: assert property (rd_ok |->
      {prdata[31:27], prdata[24]} == $past(status_flags)) else $error("flags misread");
   ca_sent_a: assert property (!reverse_mode && fwd_events.ca_cpl_tx |=>
      status_flags[1]) else $error("abort flag missed");
   tabort_rev_a: assert property (reverse_mode &&
      rev_events.target_abort_tx |=> status_flags[1]) else $error("target abort missed");
   det_perr_a: assert property (!reverse_mode &&
      fwd_events.poisoned_tlp_rx |=> status_flags[5]) else $error("poisoned flag missed");
   mdpe_gate_a: assert property ($rose(status_flags[0]) |->
      $past(perr_resp_en)) else $error("bit 24 set while disabled");
   serr_gate_a: assert property ($rose(status_flags[4]) |-> $past(serr_en))
      else $error("bit 30 set while disabled");
   w1c_clear_a: assert property (clr31 && paddr == CMD_STATUS_OFFSET &&
      fwd_events == '0 && rev_events == '0 |=> !status_flags[5]) else $error("clear ignored");
   cover property (rd_ok && reverse_mode);
   cover property (pready && pslverr);
   cover property ($fell(status_flags[5]));
endmodule : status_props

bind bridge_primary_status status_props i_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .fwd_events, .rev_events,
   .perr_resp_en, .serr_en, .reverse_mode, .status_flags);

// *** testbench.sv ***
// Self-checking bench for the primary status half-word block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import bridge_status_pkg::*;
   logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic              pwrite = 1'b0, strap = 1'b0, go = 1'b0, rev = 1'b0, pin_err = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic [3:0]        pstrb = 4'hF;
   logic [2:0]        idx = 3'h0;
   logic              pready, pslverr, pin_n, perr_resp_en, serr_en, reverse_mode, err;
   logic [5:0]        status_flags;
   fwd_events_t       fwd_events;
   rev_events_t       rev_events;
   int                error_cnt = 0, check_count = 0;
   // Row: mode, event bit, flag index
   logic [6:0]        rows [14] = '{7'h30, 7'h28, 7'h21, 7'h1A, 7'h13, 7'h0C, 7'h05,
                                    7'h78, 7'h68, 7'h61, 7'h5A, 7'h53, 7'h4C, 7'h45};
   always #2 pclk = ~pclk;
   bridge_primary_status i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .pready, .prdata, .pslverr, .reverse_mode_strap(strap),
      .primary_parity_error_pin_n(pin_n), .fwd_events, .rev_events, .perr_resp_en,
      .serr_en, .reverse_mode, .status_flags);
   far_side_model i_far (.pclk, .presetn, .go, .rev, .idx, .pin_err, .fwd_events,
      .rev_events, .primary_parity_error_pin_n(pin_n));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         error_cnt++;
         complete_run();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb
   task automatic fire(input logic r, input logic [2:0] i, input logic p);
      rev <= r;
      idx <= i;
      pin_err <= p;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (p ? 16 : 3) @(posedge pclk);
   endtask : fire
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      check({perr_resp_en, serr_en, reverse_mode, status_flags}, 9'h000);
      apb(1'b0, CMD_STATUS_OFFSET, '0);
      check(rd, 32'h0010_0000);
      fire(1'b0, 3'h6, 1'b0);
      fire(1'b0, 3'h1, 1'b0);
      fire(1'b1, 3'h2, 1'b0);
      check(status_flags, 6'h00);
      fire(1'b0, 3'h0, 1'b0);
      check(status_flags, 6'h20);
      apb(1'b1, 12'h008, 32'hFFFF_FFFF);
      check({err, status_flags}, 7'h60);
      apb(1'b0, 12'h008, '0);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      apb(1'b1, CMD_STATUS_OFFSET, 32'hFFFF_FFFF);
      apb(1'b0, CMD_STATUS_OFFSET, '0);
      check(rd, 32'h0010_0140);
      for (int k = 0; k < 14; k++) begin
         if (rows[k][6] !== reverse_mode) begin
            strap <= rows[k][6];
            repeat (8) @(posedge pclk);
            check(reverse_mode, 1'b1);
         end
         fire(rows[k][6], rows[k][5:3], 1'b0);
         check(status_flags, 6'h01 << rows[k][2:0]);
         apb(1'b0, CMD_STATUS_OFFSET, '0);
         check({rd[31:27], rd[24]}, 6'h01 << rows[k][2:0]);
         apb(1'b1, CMD_STATUS_OFFSET, 32'hF900_0140);
         check(status_flags, 6'h00);
      end
      apb(1'b0, CMD_STATUS_OFFSET, '0);
      check(rd, 32'h02B0_0140);
      fire(1'b1, 3'h0, 1'b1);
      check(status_flags, 6'h01);
      // Event and write-one clear land on the same edge
      fork
         fire(1'b1, 3'h0, 1'b0);
         apb(1'b1, CMD_STATUS_OFFSET, 32'h8100_0140);
      join
      check(status_flags, 6'h20);
      pstrb <= 4'h7;
      apb(1'b1, CMD_STATUS_OFFSET, 32'hFFFF_FFFF);
      check(status_flags, 6'h20);
      pstrb <= 4'hF;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check({perr_resp_en, serr_en, reverse_mode, status_flags}, 9'h000);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      complete_run();
   end
endmodule : testbench
